// File: logic/sbl_defines.vh
// sbl_defines.vh: protocol byte codes, answer nibbles, password and header byte counts
// assumes inclusion by the boot loader interpreter design file
`ifndef SBL_DEFINES_VH
`define SBL_DEFINES_VH
`define SBL_MODE_UART 8'h86
`define SBL_CMD_RAM 8'h10
`define SBL_CMD_ERASE 8'h40
`define SBL_CMD_ERASE_EN 8'h54
`define SBL_ACK_OK_LO 4'h0
`define SBL_ACK_BAD_LO 4'h1
`define SBL_ACK_COMM_LO 4'h8
`define SBL_ERASE_DONE 8'h4f
`define SBL_ERASE_FAIL 8'h4c
`define SBL_ERASED_BYTE 8'hff
`define SBL_PW_BYTES 12
`define SBL_HDR_BYTES 6
`define SBL_RESET_CMD_HI 4'h0
`endif

// File: logic/sbl_checksum.v
// sbl_checksum.v: running 8-bit sum of received bytes, two's complement check
// assumes clr and add come from logic on the same clock
`timescale 1ns/10ps
module sbl_checksum (
    clk,
    sys_rst,
    clr,
    add,
    din,
    ok
);
    input wire clk;
    input wire sys_rst;
    input wire clr;
    input wire add;
    input wire [7:0] din;
    output wire ok;

    reg [7:0] sum_q;
    reg [7:0] sum_d;

    // sum with carries dropped; a valid checksum byte brings the total to zero
    always @* begin
        sum_d = sum_q;
        if (clr) begin
            sum_d = 8'h00;
        end else if (add) begin
            sum_d = sum_q + din;
        end
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sum_q <= 8'h00;
        end else begin
            sum_q <= sum_d;
        end
    end

    // total including checksum byte is zero when check passes
    assign ok = (sum_q == 8'h00);
endmodule // sbl_checksum

// File: logic/sbl_loader.v
// sbl_loader.v: byte-level serial boot loader command interpreter
// assumes a serial channel delivering bytes with an error flag, and a flash erase engine
// Function
// - byte 26: 0x18 on receive error, 0x11 bad checksum, else 0x10
// - data checksum answered with comm error, 0x11 mismatch, else 0x10
// - normal final acknowledge branches execution to received start address
// - on mode byte 0x86 check baud rate possible, else stop
// - answer 0x86 if mode possible, otherwise stay silent
// - command ack: x8 on error, echo valid, x1 invalid, old upper nibble
// - synchronous serial mode skips all receive-error checks
// - compare password bytes 5..16 to flash area when required
// - byte 18: 0x40 no password, else 0x48, 0x41 or 0x40
// - byte 20: 0x58 on error, echo 0x54 and erase, else x1
// - after erase send 0x4f success or 0x4c failure, then wait
// - erased flash means 0xff password bytes are compared
// - checksum is two's complement of 8-bit sum, carries dropped
// - erase command checks password only when flash marks it needed
// - identical stored password bytes other than 0xff force 0x41 when password required
`timescale 1ns/10ps
`include "sbl_defines.vh"
module sbl_loader (
    clk,
    sys_rst,
    rx_valid,
    rx_data,
    rx_err,
    serial_channel_mode,
    baud_ok,
    pw_required,
    pw_area,
    tx_valid,
    tx_data,
    tx_ready,
    erase_start,
    erase_done,
    erase_fail,
    ram_we,
    ram_addr,
    ram_wdata,
    jump_valid,
    jump_addr,
    comm_stopped
);
    parameter PW_BYTES = `SBL_PW_BYTES;
    input wire clk;
    input wire sys_rst;
    input wire rx_valid;
    input wire [7:0] rx_data;
    input wire rx_err;
    input wire serial_channel_mode;
    input wire baud_ok;
    input wire pw_required;
    input wire [8*PW_BYTES-1:0] pw_area;
    output wire tx_valid;
    output reg [7:0] tx_data;
    input wire tx_ready;
    output reg erase_start;
    input wire erase_done;
    input wire erase_fail;
    output reg ram_we;
    output reg [31:0] ram_addr;
    output reg [7:0] ram_wdata;
    output reg jump_valid;
    output reg [31:0] jump_addr;
    output reg comm_stopped;

    localparam [3:0] S_MODE = 4'd0;
    localparam [3:0] S_CMD = 4'd1;
    localparam [3:0] S_PW = 4'd2;
    localparam [3:0] S_PWSUM = 4'd3;
    localparam [3:0] S_HDR = 4'd4;
    localparam [3:0] S_HDRSUM = 4'd5;
    localparam [3:0] S_DATA = 4'd6;
    localparam [3:0] S_DSUM = 4'd7;
    localparam [3:0] S_EN = 4'd8;
    localparam [3:0] S_ERASE = 4'd9;
    localparam [3:0] S_SEND = 4'd10;
    localparam [3:0] S_STOP = 4'd11;
    localparam [3:0] S_JUMP = 4'd12;

    reg [3:0] st_q;
    reg [3:0] nxt_q;
    reg tx_pend_q;
    reg is_ram_q;
    reg err_q;
    reg pw_bad_q;
    reg [3:0] idx_q;
    reg [3:0] cmd_hi_q;
    reg [31:0] start_q;
    reg [15:0] cnt_q;
    reg [15:0] left_q;
    reg ck_clr;
    wire ck_ok;
    wire uart;
    wire rx_bad;
    wire pw_same;
    wire [7:0] pw_byte;
    wire pw_area_bad;
    localparam [7:0] EN_CODE = `SBL_CMD_ERASE_EN;

    assign uart = serial_channel_mode;
    assign rx_bad = uart & rx_err;
    assign tx_valid = tx_pend_q;

    // stored password byte at given index; erased flash reads 0xff here
    function [7:0] pw_at;
        input [8*`SBL_PW_BYTES-1:0] area;
        input [3:0] i;
        begin
            pw_at = area[8*i +: 8];
        end
    endfunction

    // detect stored password bytes all equal and not erased
    function all_same;
        input [8*`SBL_PW_BYTES-1:0] area;
        integer k;
        begin
            all_same = (area[7:0] != `SBL_ERASED_BYTE);
            for (k = 1; k < `SBL_PW_BYTES; k = k + 1) begin
                if (area[8*k +: 8] != area[7:0]) begin
                    all_same = 1'b0;
                end
            end
        end
    endfunction

    assign pw_byte = pw_at(pw_area, idx_q);
    assign pw_same = all_same(pw_area);
    // ram transfer checks the area always, erase only when a password is needed
    assign pw_area_bad = pw_same & (is_ram_q | pw_required);

    sbl_checksum u_ck (
        .clk(clk),
        .sys_rst(sys_rst),
        .clr(ck_clr),
        .add(rx_valid),
        .din(rx_data),
        .ok(ck_ok)
    );

    // clear the running sum when a new checked range begins
    always @* begin
        ck_clr = 1'b0;
        if (rx_valid && (st_q == S_CMD)) begin
            ck_clr = 1'b1;
        end
        if (rx_valid && (st_q == S_PWSUM || st_q == S_HDRSUM)) begin
            ck_clr = 1'b1;
        end
    end

    // main byte sequencer
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= S_MODE;
            nxt_q <= S_CMD;
            tx_pend_q <= 1'b0;
            tx_data <= 8'h00;
            is_ram_q <= 1'b0;
            err_q <= 1'b0;
            pw_bad_q <= 1'b0;
            idx_q <= 4'd0;
            cmd_hi_q <= `SBL_RESET_CMD_HI;
            start_q <= 32'h0;
            cnt_q <= 16'h0;
            left_q <= 16'h0;
            erase_start <= 1'b0;
            ram_we <= 1'b0;
            ram_addr <= 32'h0;
            ram_wdata <= 8'h00;
            jump_valid <= 1'b0;
            jump_addr <= 32'h0;
            comm_stopped <= 1'b0;
        end else begin
            erase_start <= 1'b0;
            ram_we <= 1'b0;
            if (tx_pend_q && tx_ready) begin
                tx_pend_q <= 1'b0;
            end
            case (st_q)
            S_MODE: begin
                if (rx_valid) begin
                    if (rx_data == `SBL_MODE_UART && baud_ok) begin
                        tx_data <= `SBL_MODE_UART;
                        tx_pend_q <= 1'b1;
                        st_q <= S_SEND;
                        nxt_q <= S_CMD;
                    end else if (rx_data == `SBL_MODE_UART || uart) begin
                        st_q <= S_STOP;
                    end else begin
                        st_q <= S_CMD; // synchronous mode needs no answer here
                    end
                end
            end
            S_CMD: begin
                if (rx_valid) begin
                    err_q <= 1'b0;
                    pw_bad_q <= 1'b0;
                    idx_q <= 4'd0;
                    tx_pend_q <= 1'b1;
                    st_q <= S_SEND;
                    nxt_q <= S_CMD;
                    if (rx_bad) begin
                        tx_data <= {cmd_hi_q, `SBL_ACK_COMM_LO};
                    end else if (rx_data == `SBL_CMD_RAM || rx_data == `SBL_CMD_ERASE) begin
                        tx_data <= rx_data;
                        cmd_hi_q <= rx_data[7:4];
                        is_ram_q <= (rx_data == `SBL_CMD_RAM);
                        nxt_q <= S_PW;
                    end else begin
                        tx_data <= {cmd_hi_q, `SBL_ACK_BAD_LO};
                    end
                end
            end
            S_PW: begin
                if (rx_valid) begin
                    if (rx_bad) begin
                        err_q <= 1'b1;
                    end
                    if (rx_data != pw_byte) begin
                        pw_bad_q <= 1'b1;
                    end
                    idx_q <= idx_q + 4'd1;
                    if (idx_q == PW_BYTES - 1) begin
                        st_q <= S_PWSUM;
                    end
                end
            end
            S_PWSUM: begin
                if (rx_valid) begin
                    tx_pend_q <= 1'b1;
                    st_q <= S_SEND;
                    nxt_q <= S_CMD;
                    err_q <= 1'b0;
                    idx_q <= 4'd0;
                    if (!is_ram_q && !pw_required) begin
                        tx_data <= {cmd_hi_q, `SBL_ACK_OK_LO};
                        nxt_q <= S_EN;
                    end else if (err_q || rx_bad) begin
                        tx_data <= {cmd_hi_q, `SBL_ACK_COMM_LO};
                    end else if (!ck_ok_next(rx_data) || pw_bad_q || pw_area_bad) begin
                        tx_data <= {cmd_hi_q, `SBL_ACK_BAD_LO};
                    end else begin
                        tx_data <= {cmd_hi_q, `SBL_ACK_OK_LO};
                        nxt_q <= is_ram_q ? S_HDR : S_EN;
                    end
                end
            end
            S_HDR: begin
                if (rx_valid) begin
                    if (rx_bad) begin
                        err_q <= 1'b1;
                    end
                    if (idx_q < 4) begin
                        start_q <= {start_q[23:0], rx_data};
                    end else begin
                        cnt_q <= {cnt_q[7:0], rx_data};
                    end
                    idx_q <= idx_q + 4'd1;
                    if (idx_q == `SBL_HDR_BYTES - 1) begin
                        st_q <= S_HDRSUM;
                    end
                end
            end
            S_HDRSUM: begin
                if (rx_valid) begin
                    tx_pend_q <= 1'b1;
                    st_q <= S_SEND;
                    nxt_q <= S_CMD;
                    ram_addr <= start_q;
                    left_q <= cnt_q;
                    if (err_q || rx_bad) begin
                        tx_data <= {cmd_hi_q, `SBL_ACK_COMM_LO};
                    end else if (!ck_ok_next(rx_data)) begin
                        tx_data <= {cmd_hi_q, `SBL_ACK_BAD_LO};
                    end else begin
                        tx_data <= {cmd_hi_q, `SBL_ACK_OK_LO};
                        nxt_q <= (cnt_q == 16'h0) ? S_DSUM : S_DATA;
                    end
                    err_q <= 1'b0;
                end
            end
            S_DATA: begin
                if (rx_valid) begin
                    if (rx_bad) begin
                        err_q <= 1'b1;
                    end
                    ram_we <= 1'b1;
                    ram_wdata <= rx_data;
                    if (ram_we) begin
                        ram_addr <= ram_addr + 32'd1;
                    end
                    left_q <= left_q - 16'd1;
                    if (left_q == 16'd1) begin
                        st_q <= S_DSUM;
                    end
                end else if (ram_we) begin
                    ram_addr <= ram_addr + 32'd1;
                end
            end
            S_DSUM: begin
                if (rx_valid) begin
                    tx_pend_q <= 1'b1;
                    st_q <= S_SEND;
                    nxt_q <= S_CMD;
                    if (err_q || rx_bad) begin
                        tx_data <= {cmd_hi_q, `SBL_ACK_COMM_LO};
                    end else if (!ck_ok_next(rx_data)) begin
                        tx_data <= {cmd_hi_q, `SBL_ACK_BAD_LO};
                    end else begin
                        tx_data <= {cmd_hi_q, `SBL_ACK_OK_LO};
                        nxt_q <= S_JUMP;
                    end
                end
            end
            S_EN: begin
                if (rx_valid) begin
                    tx_pend_q <= 1'b1;
                    st_q <= S_SEND;
                    nxt_q <= S_CMD;
                    if (rx_bad) begin
                        tx_data <= {EN_CODE[7:4], `SBL_ACK_COMM_LO};
                    end else if (rx_data == `SBL_CMD_ERASE_EN) begin
                        tx_data <= `SBL_CMD_ERASE_EN;
                        nxt_q <= S_ERASE;
                    end else begin
                        tx_data <= {cmd_hi_q, `SBL_ACK_BAD_LO};
                    end
                end
            end
            S_ERASE: begin
                if (erase_done) begin
                    tx_data <= erase_fail ? `SBL_ERASE_FAIL : `SBL_ERASE_DONE;
                    tx_pend_q <= 1'b1;
                    st_q <= S_SEND;
                    nxt_q <= S_CMD;
                end
            end
            S_SEND: begin
                if (tx_pend_q && tx_ready) begin
                    st_q <= nxt_q;
                    if (nxt_q == S_ERASE) begin
                        erase_start <= 1'b1;
                    end
                end
            end
            S_JUMP: begin
                jump_valid <= 1'b1;
                jump_addr <= start_q;
            end
            S_STOP: begin
                comm_stopped <= 1'b1;
            end
            default: begin
                st_q <= S_MODE;
            end
            endcase
        end
    end

    // checksum byte passes when the running sum plus it wraps to zero
    function ck_ok_next;
        input [7:0] b;
        begin
            ck_ok_next = ((u_ck.sum_q + b) & 8'hff) == 8'h00;
        end
    endfunction
endmodule // sbl_loader

// File: bench/sbl_loader_properties.sv
// sbl_loader_properties.sv: port timing checks for the boot loader interpreter
// assumes one clock domain, sys_rst async and active high
`timescale 1ns/10ps
module sbl_loader_props (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic serial_channel_mode,
    input wire logic rx_valid,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_ready,
    input wire logic erase_start,
    input wire logic erase_done,
    input wire logic erase_fail,
    input wire logic ram_we,
    input wire logic [31:0] ram_addr,
    input wire logic jump_valid,
    input wire logic [31:0] jump_addr,
    input wire logic comm_stopped
);
    logic [31:0] next_q;
    logic seen_q;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // next store address within one data block, forgotten at any answer
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            next_q <= 32'h0;
            seen_q <= 1'b0;
        end else if (tx_valid) begin
            seen_q <= 1'b0;
        end else if (ram_we) begin
            next_q <= ram_addr + 32'h1;
            seen_q <= 1'b1;
        end
    end
    a_answer_stands: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("answer changed before taken");
    a_answer_cause: assert property ($rose(tx_valid) && tx_data != 8'h4f && tx_data != 8'h4c
        |-> $past(rx_valid)) else $error("answer without a byte");
    a_erase_once: assert property (erase_start |=> !erase_start)
        else $error("erase launch too long");
    a_erase_good: assert property (erase_done && !erase_fail |-> ##[1:4] tx_valid && tx_data == 8'h4f)
        else $error("no erase done code");
    a_erase_bad: assert property (erase_done && erase_fail |-> ##[1:4] tx_valid && tx_data == 8'h4c)
        else $error("no erase fail code");
    a_store_step: assert property (ram_we && seen_q |-> ram_addr == next_q)
        else $error("store address skipped");
    a_jump_holds: assert property (jump_valid |=> jump_valid && $stable(jump_addr))
        else $error("branch target moved");
    a_stop_silent: assert property (comm_stopped |=> comm_stopped && !tx_valid)
        else $error("stopped link answered");
    a_sync_no_err: assert property (!serial_channel_mode && tx_valid |-> tx_data[3:0] != 4'h8)
        else $error("link error code in sync mode");
endmodule // sbl_loader_props
bind sbl_loader sbl_loader_props u_props (.clk(clk), .sys_rst(sys_rst), .rx_valid(rx_valid),
    .serial_channel_mode(serial_channel_mode), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .erase_start(erase_start), .erase_done(erase_done),
    .erase_fail(erase_fail), .ram_we(ram_we), .ram_addr(ram_addr), .jump_valid(jump_valid),
    .jump_addr(jump_addr), .comm_stopped(comm_stopped));

// File: bench/sbl_host_model.sv
// sbl_host_model.sv: host controller on the serial byte stream
// assumes answers stand until tx_ready, all in the clk domain
`timescale 1ns/10ps
module sbl_host (
    input wire logic clk,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_err,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready
);
    // idle link at time zero
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h5a;
        rx_err = 1'b0;
        tx_ready = 1'b0;
    end
    // one byte to the device, inverted once its edge has passed
    task automatic send(input logic [7:0] b, input logic e);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_data <= b;
        rx_err <= e;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_data <= ~b;
        rx_err <= ~e;
    endtask
    // bounded wait for an answer, taken after a random stall
    task automatic get(input int lim, output logic [7:0] b);
        b = 8'hxx;
        for (int n = 0; n < lim && tx_valid !== 1'b1; n++)
            @(negedge clk);
        if (tx_valid === 1'b1) begin
            repeat ($urandom_range(2)) @(posedge clk);
            @(posedge clk);
            tx_ready <= 1'b1;
            @(posedge clk);
            b = tx_data;
            tx_ready <= 1'b0;
        end
    endtask
endmodule // sbl_host

// File: bench/serial_boot_loader_protocol_test.sv
// serial_boot_loader_protocol_test.sv: self-checking bench for the boot loader
// assumes host model, checker and design compiled before it
`timescale 1ns/10ps
module serial_boot_loader_protocol_test;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic rx_valid, rx_err, tx_valid, tx_ready, erase_start, erase_done, erase_fail, ram_we;
    logic serial_channel_mode, baud_ok, pw_required, jump_valid, comm_stopped;
    logic [7:0] rx_data, tx_data, ram_wdata;
    logic [31:0] ram_addr, jump_addr;
    logic [95:0] pw_area;
    logic [39:0] wq[$];
    int bad_count, n_tests, cyc, starts;
    sbl_loader dut (.clk(clk), .sys_rst(sys_rst), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_err(rx_err), .serial_channel_mode(serial_channel_mode), .baud_ok(baud_ok),
        .pw_required(pw_required), .pw_area(pw_area), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .erase_start(erase_start), .erase_done(erase_done),
        .erase_fail(erase_fail), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
        .jump_valid(jump_valid), .jump_addr(jump_addr), .comm_stopped(comm_stopped));
    sbl_host host (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_err(rx_err),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
    // 50 MHz clock
    always #10 clk = ~clk;
    // store and erase monitors, hang limit
    always @(posedge clk) begin
        if (ram_we === 1'b1)
            wq.push_back({ram_addr, ram_wdata});
        if (erase_start === 1'b1)
            starts++;
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            end_sim();
        end
    end
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [39:0] exp, input logic [39:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic do_reset;
        sys_rst <= 1'b1;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
    endtask
    function automatic logic [7:0] cks(input logic [7:0] d[$]);
        logic [7:0] s;
        s = 8'h00;
        foreach (d[i])
            s += d[i];
        return 8'h00 - s;
    endfunction
    task automatic ask(input logic [7:0] b, input logic e, input logic [7:0] exp, input string w);
        logic [7:0] got;
        host.send(b, e);
        host.get(40, got);
        cmp(w, exp, got);
    endtask
    // range plus checksum; m: 1 bad sum, 2 link error on first byte
    task automatic block(input logic [7:0] d[$], input int m, input logic [7:0] base,
        input logic extra, input string w, output logic ok);
        logic [7:0] exp;
        exp = (m == 2 && serial_channel_mode) ? base | 8'h08 : (m == 1 || extra) ? base | 8'h01 : base;
        foreach (d[i])
            host.send(d[i], m == 2 && i == 0);
        ask(cks(d) ^ 8'(m == 1), m == 2 && d.size() == 0, exp, w);
        ok = exp === base;
    endtask
    task automatic pw_phase(input logic [7:0] base, input int bad, input int m, output logic ok);
        logic [7:0] d[$];
        logic chk, same;
        chk = base == 8'h10 || pw_required;
        same = pw_area == {12{pw_area[7:0]}} && pw_area[7:0] != 8'hff;
        for (int i = 0; i < 12; i++)
            d.push_back(pw_area[8*i +: 8] ^ (i == bad ? 8'h20 : 8'h00));
        block(d, chk ? m : 4, base, chk && (bad >= 0 || same), "password ack", ok);
    endtask
    task automatic erase_flow(input int bad, input int m, input logic [7:0] en, input logic fail);
        logic [7:0] got, exp;
        logic ok;
        int s;
        ask(8'h40, 1'b0, 8'h40, "command echo");
        pw_phase(8'h40, bad, m, ok);
        if (!ok)
            return;
        s = starts;
        exp = (m == 3 && serial_channel_mode) ? 8'h58 : en == 8'h54 ? 8'h54 : 8'h41;
        ask(en, m == 3, exp, "enable ack");
        for (int k = 0; k < 8 && exp == 8'h54 && starts == s; k++)
            @(posedge clk);
        cmp("erase launch", 40'(s + (exp == 8'h54)), 40'(starts));
        if (exp != 8'h54)
            return;
        erase_done <= 1'b1;
        erase_fail <= fail;
        @(posedge clk);
        erase_done <= 1'b0;
        erase_fail <= ~fail;
        host.get(40, got);
        cmp("erase result", fail ? 8'h4c : 8'h4f, got);
    endtask
    task automatic ram_flow(input int n, input int hm, input int dm);
        logic [7:0] d[$];
        logic [31:0] a;
        logic ok;
        a = 32'h2000_0400 + (32'($urandom_range(255)) << 1);
        ask(8'h10, 1'b0, 8'h10, "command echo");
        pw_phase(8'h10, -1, 0, ok);
        d = {a[31:24], a[23:16], a[15:8], a[7:0], 8'(n >> 8), 8'(n)};
        block(d, hm, 8'h10, 1'b0, "header ack", ok);
        if (!ok)
            return;
        d = {};
        repeat (n)
            d.push_back(8'($urandom));
        wq = {};
        block(d, dm, 8'h10, 1'b0, "data ack", ok);
        cmp("store count", 40'(n), 40'(wq.size()));
        foreach (d[i])
            cmp("store", {a + 32'(i), d[i]}, wq[i]);
        for (int k = 0; k < 20 && ok && jump_valid !== 1'b1; k++)
            @(posedge clk);
        cmp("branch", {7'h0, ok, ok ? a : 32'h0}, {7'h0, jump_valid, jump_valid ? jump_addr : 32'h0});
    endtask
    // main sequence
    initial begin
        serial_channel_mode = 1'b1;
        baud_ok = 1'b1;
        pw_required = 1'b1;
        erase_done = 1'b0;
        erase_fail = 1'b0;
        void'($urandom(32'h8de0));
        pw_area = {$urandom, $urandom, $urandom};
        do_reset();
        ask(8'h86, 1'b0, 8'h86, "mode echo");
        ask(8'h33, 1'b0, 8'h01, "command refused");
        erase_flow(-1, 0, 8'h54, 1'b0);
        ask(8'h40, 1'b1, 8'h48, "command error");
        erase_flow(-1, 0, 8'h54, 1'b1);
        erase_flow(3, 0, 8'h54, 1'b0);
        erase_flow(-1, 1, 8'h54, 1'b0);
        erase_flow(-1, 2, 8'h54, 1'b0);
        erase_flow(-1, 3, 8'h54, 1'b0);
        erase_flow(-1, 0, 8'h55, 1'b0);
        ask(8'h77, 1'b0, 8'h41, "command refused");
        pw_required <= 1'b0;
        erase_flow(5, 1, 8'h54, 1'b0);
        pw_required <= 1'b1;
        pw_area <= {12{8'h5a}};
        erase_flow(-1, 0, 8'h54, 1'b0);
        $display("test erase finished");
        pw_area <= {12{8'hff}};
        ram_flow(4, 1, 0);
        ram_flow(4, 2, 0);
        ram_flow(3, 0, 1);
        ram_flow(3, 0, 2);
        ram_flow($urandom_range(8, 1), 0, 0);
        $display("test ram finished");
        baud_ok <= 1'b0;
        do_reset();
        ask(8'h86, 1'b0, 8'hxx, "silent mode");
        cmp("stopped", 40'h1, {39'h0, comm_stopped});
        $display("test baud finished");
        baud_ok <= 1'b1;
        serial_channel_mode <= 1'b0;
        do_reset();
        host.send(8'h00, 1'b1);
        erase_flow(-1, 2, 8'h54, 1'b0);
        erase_flow(-1, 3, 8'h54, 1'b0);
        ram_flow(2, 2, 2);
        $display("test sync finished");
        end_sim();
    end
endmodule // serial_boot_loader_protocol_test
